// *** logic/ssc_pkg.sv ***
// Purpose: shared constants and types of the stepper sequencer control block
// Assumes: 100 MHz core clock, 32 sequencer positions per electrical cycle
// Notes:   level codes are the current-ratio mode codes, zero meaning phase off
package ssc_pkg;

	localparam int CLOCK_PERIOD_NS         = 10;
	// least time between a wake from either sleep and the next step edge
	localparam int SLEEP_WAKE_DELAY_NS     = 100000;
	localparam int SLEEP_WAKE_DELAY_CYCLES = (SLEEP_WAKE_DELAY_NS + CLOCK_PERIOD_NS - 1)
		/ CLOCK_PERIOD_NS;
	localparam int WAKE_CNT_W              = 14;

	localparam int POS_W                   = 5;
	localparam logic [4:0] POS_RESET       = 5'h00;
	// distance from position to the phase A peak angle
	localparam logic [4:0] DIAG_OFFSET     = 5'h04;
	localparam logic [4:0] PHASE_B_OFFSET  = 5'h08;
	localparam logic [4:0] FULL_STEP_SIZE  = 5'h08;
	localparam logic [3:0] DIST_DIAGONAL   = 4'h4;
	localparam logic [3:0] DIST_FOLD       = 4'h8;

	localparam logic [3:0] LEVEL_OFF       = 4'h0;
	localparam logic [3:0] LEVEL_2         = 4'h2;
	localparam logic [3:0] LEVEL_4         = 4'h4;
	localparam logic [3:0] LEVEL_6         = 4'h6;
	localparam logic [3:0] LEVEL_8         = 4'h8;
	localparam logic [3:0] LEVEL_A         = 4'hA;
	localparam logic [3:0] LEVEL_C         = 4'hC;
	localparam logic [3:0] LEVEL_E         = 4'hE;
	localparam logic [3:0] LEVEL_F         = 4'hF;
	localparam logic [3:0] LEVEL_RESET     = 4'hF;

	typedef logic [WAKE_CNT_W-1:0] ssc_wake_t;

	// step mode, coded as {step_mode_select_b, step_mode_select_a}
	typedef enum logic [1:0] {
		MODE_FULL    = 2'b00,
		MODE_HALF    = 2'b01,
		MODE_QUARTER = 2'b10,
		MODE_EIGHTH  = 2'b11
	} ssc_mode_e;

	localparam ssc_mode_e MODE_RESET = MODE_FULL;

	typedef struct packed {
		logic stepClock;
		logic direction;
		logic modeA;
		logic modeB;
		logic deepSleep;
		logic lightSleep;
		logic chopSync;
		logic protEvent;
	} ssc_pins_s;

	typedef struct packed {
		logic [4:0] position;
		ssc_mode_e  mode;
		logic       stepPrev;
		logic       protLatched;
		logic       fullStep;
		logic [3:0] levelA;
		logic       negA;
		logic [3:0] levelB;
		logic       negB;
		logic       chopAlign;
		ssc_wake_t  wakeCount;
	} ssc_state_s;

endpackage

// *** logic/ssc_pin_filter.sv ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clock
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/1ps
module ssc_pin_filter #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock,       // core clock
	input  wire logic             rst,         // async reset, active high
	input  wire logic             clockEnable, // freezes all stages while low
	input  wire logic [WIDTH-1:0] rawIn,       // asynchronous pin levels
	output logic      [WIDTH-1:0] cleanOut     // filtered levels
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} ssc_filt_s;

	ssc_filt_s f_r;
	ssc_filt_s f_nxt;

	always_comb begin
		f_nxt = f_r;
		f_nxt.s1 = rawIn;
		// s1 feeds s2 only, it may still be metastable
		f_nxt.s2 = f_r.s1;
		f_nxt.s3 = f_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (f_r.s2[i] == f_r.s3[i]) begin
				f_nxt.out[i] = f_r.s3[i];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			f_r <= '0;
		end else if (clockEnable) begin
			f_r <= f_nxt;
		end
	end

	assign cleanOut = f_r.out;

endmodule

// *** logic/ssc_sequencer.sv ***
// Purpose: step sequencer, sleep control and monitor outputs of a stepper driver
// Assumes: protection detection and power stage sit outside this block
// Notes:   all pins but reset and clock enable pass a three-stage filter, so response lags those pins by about four cycles
//
// Summary of operation
// R1 - sequencer advances only on step rising edge
// R2 - host keeps step high and low over 2us
// R3 - host keeps direction and mode 1us from edge
// R4 - mode select bits pick full/half/quarter/eighth
// R5 - direction low forward, high reverse
// R6 - direction and mode take effect at next edge
// R7 - reset returns sequencer to starting point asynchronously
// R8 - output disable ignored while reset is high
// R9 - host holds reset high over 2us
// R10 - host waits 5us after reset before stepping
// R11 - light sleep disables outputs, sequencer keeps stepping
// R12 - deep sleep disables outputs, ignores step edges
// R13 - deep sleep clears latched protection state
// R14 - host waits 100us after wake before stepping
// R15 - full-step monitor high at two-phase positions
// R16 - protection monitor high while protection active
// R17 - monitor outputs are open drain, pull low only
// R18 - board ties unused inputs to fixed levels
// R19 - each edge moves to next state in direction
// R20 - chop sync high aligns off-time of phases
// R21 - diagonal level 70.7 for quarter/eighth, full otherwise
// R22 - 32-state counter, step 8/4/2/1 per mode
`timescale 1ns/1ps
module ssc_sequencer #(
	parameter ssc_pkg::ssc_wake_t WAKE_CYCLES =
		ssc_pkg::ssc_wake_t'(ssc_pkg::SLEEP_WAKE_DELAY_CYCLES)
) (
	input  wire logic       clock,                 // core clock, 100 MHz
	input  wire logic       rst,                   // logic reset pin, async, active high
	input  wire logic       clockEnable,           // freezes all state while low
	input  wire logic       stepClockIn,           // step clock pin
	input  wire logic       rotationDirectionIn,   // low forward, high reverse
	input  wire logic       stepModeSelectA,       // step mode select, first bit
	input  wire logic       stepModeSelectB,       // step mode select, second bit
	input  wire logic       deepSleepIn,           // deep sleep, high holds sequencer
	input  wire logic       referenceLightSleepIn, // light sleep level, high sleeps
	input  wire logic       chopSyncIn,            // high aligns chopping of both phases
	input  wire logic       protectionEventIn,     // protection detector trip
	output logic            outputEnableOut,       // power stage enable
	output logic      [3:0] phaseALevelOut,        // phase A current ratio code
	output logic            phaseANegativeOut,     // phase A driven on inverted output
	output logic      [3:0] phaseBLevelOut,        // phase B current ratio code
	output logic            phaseBNegativeOut,     // phase B driven on inverted output
	output logic            chopSyncAlignOut,      // aligned chopping request
	output logic      [4:0] positionOut,           // sequencer position 0..31
	output logic            wakeReadyOut,          // wake delay has elapsed
	output logic            fullStepMonitorOut,    // open-drain data, always low
	output logic            fullStepMonitorOe,     // high pulls full-step monitor low
	output logic            protectionMonitorOut,  // open-drain data, always low
	output logic            protectionMonitorOe    // high pulls protection monitor low
);

	ssc_pkg::ssc_pins_s  pinsRaw;
	ssc_pkg::ssc_pins_s  pinsClean;
	ssc_pkg::ssc_state_s s_r;
	ssc_pkg::ssc_state_s s_nxt;
	ssc_pkg::ssc_mode_e  modeNow;
	logic                stepEdge;
	logic                stepAccept;
	logic [4:0]          stepSize;
	logic [4:0]          aligned;
	logic [4:0]          angleA;
	logic [4:0]          angleB;
	logic [3:0]          distA;
	logic [3:0]          distB;
	logic                coarseMode;

	assign pinsRaw = '{
		stepClock:  stepClockIn,
		direction:  rotationDirectionIn,
		modeA:      stepModeSelectA,
		modeB:      stepModeSelectB,
		deepSleep:  deepSleepIn,
		lightSleep: referenceLightSleepIn,
		chopSync:   chopSyncIn,
		protEvent:  protectionEventIn
	};

	ssc_pin_filter #(
		.WIDTH($bits(ssc_pkg::ssc_pins_s))
	) u_pins (
		.clock       (clock),
		.rst         (rst),
		.clockEnable (clockEnable),
		.rawIn       (pinsRaw),
		.cleanOut    (pinsClean)
	);

	// distance of an angle to the nearest peak of its phase, 0..8
	function automatic logic [3:0] foldDist(input logic [3:0] x);
		foldDist = (x <= ssc_pkg::DIST_FOLD) ? x : 4'h0 - x;
	endfunction

	function automatic logic [3:0] levelOf(input logic [3:0] d, input logic coarse);
		unique case (d)
			4'h0:    levelOf = ssc_pkg::LEVEL_F;
			4'h1:    levelOf = ssc_pkg::LEVEL_E;
			4'h2:    levelOf = ssc_pkg::LEVEL_C;
			4'h3:    levelOf = ssc_pkg::LEVEL_A;
			// full and half step drive the diagonal at full level
			4'h4:    levelOf = coarse ? ssc_pkg::LEVEL_F : ssc_pkg::LEVEL_8; // [R21]
			4'h5:    levelOf = ssc_pkg::LEVEL_6;
			4'h6:    levelOf = ssc_pkg::LEVEL_4;
			4'h7:    levelOf = ssc_pkg::LEVEL_2;
			default: levelOf = ssc_pkg::LEVEL_OFF;
		endcase
	endfunction

	// negative half of the phase: angles 9..23 from its peak
	function automatic logic isNeg(input logic [4:0] a);
		isNeg = (a > 5'h08) && (a < 5'h18);
	endfunction

	always_comb begin
		s_nxt = s_r;
		modeNow = ssc_pkg::ssc_mode_e'({pinsClean.modeB, pinsClean.modeA}); // [R4]
		stepEdge = pinsClean.stepClock && !s_r.stepPrev; // [R1]
		// deep sleep holds the sequencer, light sleep does not
		stepAccept = stepEdge && !pinsClean.deepSleep; // [R12] [R11]
		s_nxt.stepPrev = pinsClean.stepClock;
		// 8, 4, 2 or 1 positions per step
		stepSize = ssc_pkg::FULL_STEP_SIZE >> modeNow; // [R22]
		aligned = s_r.position & ~(stepSize - 5'h01);
		if (stepAccept) begin
			// mode and direction are sampled only here, so changes wait for an edge
			s_nxt.mode = modeNow; // [R6]
			if (pinsClean.direction) begin
				// an off-grid position snaps back, which already counts as a step
				s_nxt.position = (s_r.position == aligned) ? aligned - stepSize : aligned; // [R5] [R19]
			end else begin
				s_nxt.position = aligned + stepSize; // [R5] [R19]
			end
		end
		angleA = s_nxt.position + ssc_pkg::DIAG_OFFSET;
		angleB = angleA - ssc_pkg::PHASE_B_OFFSET;
		distA = foldDist(angleA[3:0]);
		distB = foldDist(angleB[3:0]);
		coarseMode = (s_nxt.mode == ssc_pkg::MODE_FULL) || (s_nxt.mode == ssc_pkg::MODE_HALF);
		s_nxt.levelA = levelOf(distA, coarseMode); // [R21]
		s_nxt.levelB = levelOf(distB, coarseMode); // [R21]
		s_nxt.negA = isNeg(angleA);
		s_nxt.negB = isNeg(angleB);
		s_nxt.fullStep = (s_nxt.position[2:0] == 3'h0); // [R15]
		// a trip in the clearing cycle still latches
		if (pinsClean.protEvent) begin
			s_nxt.protLatched = 1'b1; // [R16]
		end else if (pinsClean.deepSleep) begin
			s_nxt.protLatched = 1'b0; // [R13]
		end
		s_nxt.chopAlign = pinsClean.chopSync; // [R20]
		if (pinsClean.deepSleep || pinsClean.lightSleep) begin
			s_nxt.wakeCount = WAKE_CYCLES; // [R14]
		end else if (s_r.wakeCount != '0) begin
			s_nxt.wakeCount = s_r.wakeCount - ssc_pkg::ssc_wake_t'(1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r.position <= ssc_pkg::POS_RESET; // [R7]
			s_r.mode <= ssc_pkg::MODE_RESET;
			s_r.stepPrev <= 1'b0;
			s_r.protLatched <= 1'b0;
			s_r.fullStep <= 1'b1;
			s_r.levelA <= ssc_pkg::LEVEL_RESET;
			s_r.negA <= 1'b0;
			s_r.levelB <= ssc_pkg::LEVEL_RESET;
			s_r.negB <= 1'b0;
			s_r.chopAlign <= 1'b0;
			s_r.wakeCount <= '0;
		end else if (clockEnable) begin
			s_r <= s_nxt;
		end
	end

	// the filtered light sleep is held at zero by reset, so the raw pin decides here;
	// protection and deep sleep cannot turn the stage off while reset is high
	assign outputEnableOut = rst ? !referenceLightSleepIn // [R7] [R8]
		: !(pinsClean.lightSleep || pinsClean.deepSleep || s_r.protLatched); // [R11] [R12]

	assign phaseALevelOut = s_r.levelA;
	assign phaseANegativeOut = s_r.negA;
	assign phaseBLevelOut = s_r.levelB;
	assign phaseBNegativeOut = s_r.negB;
	assign chopSyncAlignOut = s_r.chopAlign;
	assign positionOut = s_r.position;
	assign wakeReadyOut = (s_r.wakeCount == '0);

	// monitors only ever pull low; high comes from the board pull-up
	assign fullStepMonitorOut = 1'b0; // [R17]
	assign fullStepMonitorOe = !s_r.fullStep; // [R15] [R17]
	assign protectionMonitorOut = 1'b0; // [R17]
	assign protectionMonitorOe = !s_r.protLatched; // [R16] [R17]

	a_step_needs_edge: assert property (@(posedge clock) disable iff (rst) // [R1]
		!stepAccept |=> $stable(s_r.position))
		else $error("position moved without a step edge");

	a_eighth_forward: assert property (@(posedge clock) disable iff (rst) // [R22]
		(stepAccept && clockEnable && modeNow == ssc_pkg::MODE_EIGHTH && !pinsClean.direction)
		|=> s_r.position == 5'($past(s_r.position) + 5'h01))
		else $error("eighth step forward did not advance by one");

	a_full_reverse: assert property (@(posedge clock) disable iff (rst) // [R5]
		(stepAccept && clockEnable && modeNow == ssc_pkg::MODE_FULL && pinsClean.direction
			&& s_r.position[2:0] == 3'h0)
		|=> s_r.position == 5'($past(s_r.position) - 5'h08))
		else $error("full step reverse did not retreat by eight");

	a_mode_at_edge: assert property (@(posedge clock) disable iff (rst) // [R6]
		!(stepAccept && clockEnable) |=> $stable(s_r.mode))
		else $error("step mode changed between edges");

	a_deep_hold: assert property (@(posedge clock) disable iff (rst) // [R12]
		pinsClean.deepSleep [*2] |-> !outputEnableOut ##1 $stable(s_r.position))
		else $error("deep sleep did not hold the sequencer");

	a_prot_release: assert property (@(posedge clock) disable iff (rst) // [R13]
		(clockEnable && pinsClean.deepSleep && !pinsClean.protEvent)
		|=> !s_r.protLatched && protectionMonitorOe)
		else $error("deep sleep did not release protection");

	a_prot_flag: assert property (@(posedge clock) disable iff (rst) // [R16]
		// only a deep sleep in the first cycle may release it in the second
		(clockEnable && pinsClean.protEvent) |=> !protectionMonitorOe
			##1 (!protectionMonitorOe || $past(pinsClean.deepSleep)))
		else $error("protection monitor not released high after trip");

	a_full_monitor: assert property (@(posedge clock) disable iff (rst) // [R15]
		fullStepMonitorOe == (s_r.position[2:0] != 3'h0))
		else $error("full-step monitor disagrees with position");

	a_diag_level: assert property (@(posedge clock) disable iff (rst) // [R21]
		(s_r.position[2:0] == 3'h0) |-> (s_r.levelA == s_r.levelB)
			&& (s_r.levelA == ((s_r.mode == ssc_pkg::MODE_FULL || s_r.mode == ssc_pkg::MODE_HALF)
				? ssc_pkg::LEVEL_F : ssc_pkg::LEVEL_8)))
		else $error("wrong current level at a diagonal position");

	a_light_steps: assert property (@(posedge clock) disable iff (rst) // [R11]
		(pinsClean.lightSleep && !pinsClean.deepSleep) |-> !outputEnableOut
			&& (stepAccept == stepEdge))
		else $error("light sleep handling wrong");

	a_reset_drive: assert property (@(posedge clock) // [R8]
		(rst && !referenceLightSleepIn) |-> outputEnableOut && positionOut == ssc_pkg::POS_RESET)
		else $error("outputs not driven at start point during reset");

	a_chop_follow: assert property (@(posedge clock) disable iff (rst) // [R20]
		clockEnable |=> chopSyncAlignOut == $past(pinsClean.chopSync))
		else $error("chop alignment did not follow the input");

	// the clock enable freezes the whole state word, pin filter included
	a_freeze_hold: assert property (@(posedge clock) disable iff (rst) // [R1]
		!clockEnable |=> $stable(s_r))
		else $error("state moved while the clock enable was low");

	a_step_once: assert property (@(posedge clock) disable iff (rst) // [R1]
		(stepAccept && clockEnable) |=> !stepAccept)
		else $error("one step edge was taken twice");

	a_mode_latch: assert property (@(posedge clock) disable iff (rst) // [R4]
		(stepAccept && clockEnable) |=> s_r.mode == $past(modeNow))
		else $error("step mode not taken at the step edge");

	a_half_forward: assert property (@(posedge clock) disable iff (rst) // [R22]
		(stepAccept && clockEnable && modeNow == ssc_pkg::MODE_HALF && !pinsClean.direction)
		|=> s_r.position == 5'(($past(s_r.position) & 5'h1C) + 5'h04))
		else $error("half step forward did not reach the next half step");

	// only aligned starts are checked here; an off-grid start snaps instead
	a_quarter_reverse: assert property (@(posedge clock) disable iff (rst) // [R5]
		(stepAccept && clockEnable && modeNow == ssc_pkg::MODE_QUARTER && pinsClean.direction
			&& !s_r.position[0])
		|=> s_r.position == 5'($past(s_r.position) - 5'h02))
		else $error("quarter step reverse did not retreat by two");

	a_one_phase_on: assert property (@(posedge clock) disable iff (rst) // [R19]
		(s_r.levelA != ssc_pkg::LEVEL_OFF) || (s_r.levelB != ssc_pkg::LEVEL_OFF))
		else $error("both phases off at a sequencer position");

	a_prot_hold: assert property (@(posedge clock) disable iff (rst) // [R16]
		(s_r.protLatched && !pinsClean.deepSleep) |=> s_r.protLatched)
		else $error("protection released without deep sleep");

	a_prot_disable: assert property (@(posedge clock) disable iff (rst) // [R16]
		s_r.protLatched |-> !outputEnableOut && !protectionMonitorOe)
		else $error("latched protection left the outputs on");

	a_wake_hold: assert property (@(posedge clock) disable iff (rst) // [R14]
		(clockEnable && (pinsClean.deepSleep || pinsClean.lightSleep)) |=> !wakeReadyOut)
		else $error("wake ready raised while asleep");

	a_wake_count: assert property (@(posedge clock) disable iff (rst) // [R14]
		(clockEnable && !pinsClean.deepSleep && !pinsClean.lightSleep && !wakeReadyOut)
		|=> s_r.wakeCount
			== ssc_pkg::ssc_wake_t'($past(s_r.wakeCount) - ssc_pkg::ssc_wake_t'(1)))
		else $error("wake delay did not count down by one");

	// reset is asynchronous, so the state already sits at the start point when sampled
	a_reset_state: assert property (@(posedge clock) // [R7]
		rst |-> positionOut == ssc_pkg::POS_RESET && s_r.mode == ssc_pkg::MODE_RESET
			&& protectionMonitorOe && !fullStepMonitorOe)
		else $error("state not at the start point during reset");

endmodule

// *** verif/ssc_host_model.sv ***
// Purpose: host controller model driving step clock, direction and mode pins
// Assumes: the design reacts to a pin change within five core cycles
// Notes:   pin timing is scaled to core cycles so the run stays short
`timescale 1ns/1ps
module ssc_host_model (
	input  wire logic clock,     // core clock
	output logic      stepClock, // step clock pin
	output logic      direction, // rotation direction pin
	output logic      modeA,     // step mode select, first bit
	output logic      modeB      // step mode select, second bit
);
	localparam int PHASE_CYCLES = 6;

	// no pin is ever left floating, even before the first command
	initial begin
		stepClock = 1'b0;
		direction = 1'b0;
		modeA     = 1'b0;
		modeB     = 1'b0;
	end

	// direction and mode move only while the step clock is quiet
	task automatic setup(input logic dir, input logic [1:0] mode);
		@(posedge clock);
		direction <= dir;
		{modeB, modeA} <= mode;
		repeat (PHASE_CYCLES) @(posedge clock);
	endtask

	task automatic pulse();
		@(posedge clock);
		stepClock <= 1'b1;
		repeat (PHASE_CYCLES) @(posedge clock);
		stepClock <= 1'b0;
		repeat (PHASE_CYCLES) @(posedge clock);
	endtask

	// quiet time after reset release or wake before the next step edge
	task automatic settle(input int cycles);
		repeat (cycles) @(posedge clock);
	endtask
endmodule

// *** verif/tb_stepper_sequencer_control.sv ***
// Purpose: self-checking bench of the stepper sequencer control block
// Assumes: wake delay shortened to 8 cycles through the design parameter
// Notes:   expected positions and levels are tracked here independently
`timescale 1ns/1ps
module tb_stepper_sequencer_control;
	localparam ssc_pkg::ssc_wake_t WAKE = 14'h0008;
	logic       clock, rst, clockEnable, deepSleep, lightSleep, chopSync, protEvent;
	logic       stepClock, direction, modeA, modeB;
	logic       outEn, negA, negB, chopAlign, wakeReady, fsOut, fsOe, prOut, prOe;
	logic [3:0] levelA, levelB;
	logic [4:0] position;
	int         fail_count = 0;
	int         checks = 0;
	int         pos = 0;

	ssc_host_model i_ssc_host_model (.clock(clock), .stepClock(stepClock),
		.direction(direction), .modeA(modeA), .modeB(modeB));

	ssc_sequencer #(.WAKE_CYCLES(WAKE)) i_ssc_sequencer (.clock(clock), .rst(rst),
		.clockEnable(clockEnable), .stepClockIn(stepClock), .rotationDirectionIn(direction),
		.stepModeSelectA(modeA), .stepModeSelectB(modeB), .deepSleepIn(deepSleep),
		.referenceLightSleepIn(lightSleep), .chopSyncIn(chopSync),
		.protectionEventIn(protEvent), .outputEnableOut(outEn), .phaseALevelOut(levelA),
		.phaseANegativeOut(negA), .phaseBLevelOut(levelB), .phaseBNegativeOut(negB),
		.chopSyncAlignOut(chopAlign), .positionOut(position), .wakeReadyOut(wakeReady),
		.fullStepMonitorOut(fsOut), .fullStepMonitorOe(fsOe),
		.protectionMonitorOut(prOut), .protectionMonitorOe(prOe));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// the 1 ns lag keeps reads clear of the edge that updates the outputs
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		#1;
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %0h seen %0h", name, exp, got);
		end
	endtask

	// sign and ratio code of a phase whose peak sits at angle 0
	function automatic logic [4:0] expLevel(input int angle, input int mode);
		logic [3:0] tbl [0:8] = '{4'hF, 4'hE, 4'hC, 4'hA, 4'h8, 4'h6, 4'h4, 4'h2, 4'h0};
		int a = angle & 31;
		int d = a % 16;
		if (d > 8) begin
			d = 16 - d;
		end
		return {(a >= 9 && a <= 23), (d == 4 && mode < 2) ? 4'hF : tbl[d]};
	endfunction

	task automatic checkState(input int mode);
		chk("position", {3'h0, pos[4:0]}, {3'h0, position});
		chk("phaseA", {3'h0, expLevel(pos + 4, mode)}, {3'h0, negA, levelA});
		chk("phaseB", {3'h0, expLevel(pos - 4, mode)}, {3'h0, negB, levelB});
		chk("fullStepOe", {7'h0, pos[2:0] != 3'h0}, {7'h0, fsOe});
		chk("monitorData", 8'h00, {6'h0, fsOut, prOut});
	endtask

	// pin changes land on a rising edge, as the host would make them
	task automatic drivePins(input logic [4:0] v);
		@(posedge clock);
		{clockEnable, deepSleep, lightSleep, chopSync, protEvent} <= v;
	endtask

	task automatic doReset();
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		i_ssc_host_model.settle(8);
		pos = 0;
	endtask

	task automatic testReset();
		checkState(0);
		chk("protOe", 8'h01, {7'h0, prOe});
		chk("outEn", 8'h01, {7'h0, outEn});
	endtask

	task automatic testEighthCycle();
		i_ssc_host_model.setup(1'b0, 2'b11);
		for (int i = 0; i < 32; i++) begin
			i_ssc_host_model.pulse();
			pos = (pos + 1) & 31;
			checkState(3);
		end
	endtask

	task automatic testModes();
		for (int m = 0; m < 4; m++) begin
			doReset();
			i_ssc_host_model.setup(1'b0, m[1:0]);
			i_ssc_host_model.pulse();
			pos = 8 >> m;
			checkState(m);
			i_ssc_host_model.setup(1'b1, m[1:0]);
			checkState(m);
			i_ssc_host_model.pulse();
			i_ssc_host_model.pulse();
			pos = 32 - (8 >> m);
			checkState(m);
		end
	endtask

	task automatic testDeepSleep();
		drivePins(5'h11);
		i_ssc_host_model.settle(8);
		drivePins(5'h10);
		i_ssc_host_model.settle(8);
		chk("protOe", 8'h00, {7'h0, prOe});
		chk("outEn", 8'h00, {7'h0, outEn});
		drivePins(5'h18);
		i_ssc_host_model.settle(8);
		chk("protOe", 8'h01, {7'h0, prOe});
		chk("outEn", 8'h00, {7'h0, outEn});
		i_ssc_host_model.pulse();
		checkState(3);
		drivePins(5'h10);
		i_ssc_host_model.settle(2);
		chk("wakeReady", 8'h00, {7'h0, wakeReady});
		i_ssc_host_model.settle(int'(WAKE) + 8);
		chk("wakeReady", 8'h01, {7'h0, wakeReady});
		chk("outEn", 8'h01, {7'h0, outEn});
	endtask

	task automatic testLightSleep();
		i_ssc_host_model.setup(1'b0, 2'b11);
		drivePins(5'h16);
		i_ssc_host_model.settle(8);
		chk("outEn", 8'h00, {7'h0, outEn});
		chk("chopAlign", 8'h01, {7'h0, chopAlign});
		i_ssc_host_model.pulse();
		pos = (pos + 1) & 31;
		checkState(3);
		drivePins(5'h10);
		i_ssc_host_model.settle(int'(WAKE) + 8);
		chk("outEn", 8'h01, {7'h0, outEn});
		chk("chopAlign", 8'h00, {7'h0, chopAlign});
	endtask

	// a step pulse that starts and ends inside a freeze never reaches the sequencer
	task automatic testFreeze();
		drivePins(5'h00);
		i_ssc_host_model.pulse();
		drivePins(5'h10);
		i_ssc_host_model.settle(8);
		checkState(3);
		i_ssc_host_model.pulse();
		pos = (pos + 1) & 31;
		checkState(3);
	endtask

	task automatic testResetOverride();
		drivePins(5'h18);
		rst <= 1'b1;
		i_ssc_host_model.settle(8);
		chk("outEn", 8'h01, {7'h0, outEn});
		drivePins(5'h10);
		rst <= 1'b0;
		i_ssc_host_model.settle(int'(WAKE) + 8);
		pos = 0;
		checkState(0);
	endtask

	initial begin
		rst = 1'b0;
		clockEnable = 1'b1;
		deepSleep = 1'b0;
		lightSleep = 1'b0;
		chopSync = 1'b0;
		protEvent = 1'b0;
		// a real rising reset edge before the first clock, so no flop starts unknown
		#1 rst = 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		i_ssc_host_model.settle(8);
		testReset();
		testEighthCycle();
		testModes();
		testDeepSleep();
		testLightSleep();
		testFreeze();
		testResetOverride();
		tally_and_finish();
	end

	// whole run needs under 1000 cycles; cut off well beyond that
	initial begin
		#500000;
		fail_count++;
		tally_and_finish();
	end
endmodule
